// ---- src/irq_priority_pick.sv ----
// Fixed-priority selector returning vector code and level
`timescale 1ns/1ps
`include "irq_vec_consts.svh"
module irq_priority_pick (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // Pending unmasked requests
  input  wire irq_vec_pkg::src_vec_t req_i,
  // Registered winner
  output irq_vec_pkg::grant_t     grant_o
);
  import irq_vec_pkg::*;
  grant_t next_grant;

  always_comb begin
    next_grant = '{valid: 1'b0, code: `VEC_NONE, level: 3'h0};
    if (req_i[`BIT_RECEIVER]) begin
      next_grant = '{valid: 1'b1, code: `VEC_RECEIVER, level: `PRIO_RECEIVER};
    end else if (req_i[`BIT_TRANSMITTER]) begin
      next_grant = '{valid: 1'b1, code: `VEC_TRANSMITTER, level: `PRIO_TRANSMITTER};
    end else if (req_i[`BIT_TURNAROUND]) begin
      next_grant = '{valid: 1'b1, code: `VEC_TURNAROUND, level: `PRIO_TURNAROUND};
    end else if (req_i[`BIT_BIDIR]) begin
      next_grant = '{valid: 1'b1, code: `VEC_BIDIR, level: `PRIO_BIDIR};
    end else if (req_i[`BIT_TIMER]) begin
      next_grant = '{valid: 1'b1, code: `VEC_TIMER, level: `PRIO_TIMER};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      grant_o <= '{valid: 1'b0, code: `VEC_NONE, level: 3'h0};
    end else begin
      grant_o <= next_grant;
    end
  end
endmodule

// ---- src/irq_vec_consts.svh ----
// Constants for the interrupt vector and mask block
`ifndef IRQ_VEC_CONSTS_SVH
`define IRQ_VEC_CONSTS_SVH
`define NUM_SRC           5
`define VEC_RECEIVER      6'h04
`define VEC_TRANSMITTER   6'h08
`define VEC_TURNAROUND    6'h0C
`define VEC_BIDIR         6'h10
`define VEC_TIMER         6'h14
`define VEC_NONE          6'h00
`define PRIO_RECEIVER     3'h1
`define PRIO_TRANSMITTER  3'h2
`define PRIO_TURNAROUND   3'h3
`define PRIO_BIDIR        3'h4
`define PRIO_TIMER        3'h5
`define BIT_RECEIVER      0
`define BIT_TRANSMITTER   1
`define BIT_TURNAROUND    2
`define BIT_BIDIR         3
`define BIT_TIMER         4
`define ADDR_MASK         12'h000
`define ADDR_STATUS       12'h004
`define ADDR_ENABLE       12'h008
`define ADDR_VECTOR       12'h00C
`define ADDR_CONFIG       12'h010
`define ADDR_RAW          12'h014
`define RST_MASK          5'h00
`define RST_ENABLE        5'h00
`define RST_CONFIG        1'h0
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ---- src/irq_vec_pkg.sv ----
// Types for the interrupt vector and mask block
`include "irq_vec_consts.svh"
package irq_vec_pkg;
  typedef logic [`NUM_SRC-1:0] src_vec_t;
  typedef logic [5:0]          vector_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;
  typedef struct packed {
    logic    valid;
    vector_t code;
    logic [2:0] level;
  } grant_t;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;
endpackage

// ---- src/irq_vector_mask.sv ----
// Interrupt mask, sticky status, vectoring and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "irq_vec_consts.svh"
// What this block does
// - Timer vector 010100, lowest level five
// - Bidirectional vector 010000, level four
// - Five-bit mask, zero masks none, bit0 receiver
// - Bits: 1 transmit, 2 turnaround, 3 bidir, 4 timer
// - Set mask bit blocks its source, except bit 3 in output mode
// - Bidir pin output: bit 3 drives level
module irq_vector_mask (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  SRST_I,
  // Interrupt sources, same clock domain
  input  wire irq_vec_pkg::src_vec_t SRC_REQ_I,
  // Bidirectional request pin
  input  wire logic                  BIDIR_PIN_I,
  output logic                       BIDIR_PIN_O,
  output logic                       BIDIR_PIN_OE_O,
  // Vector output
  output logic                       IRQ_O,
  output irq_vec_pkg::vector_t       VECTOR_O,
  output logic [2:0]                 LEVEL_O,
  // AXI4-Lite write address
  input  wire logic [11:0]           S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [11:0]           S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY
);
  import irq_vec_pkg::*;

  src_vec_t  interrupt_mask_field;
  src_vec_t  status;
  src_vec_t  enable;
  logic      bidir_pin_is_output;
  logic      pin_meta;
  logic      pin_sync;
  logic      pin_prev;
  src_vec_t  raw_req;
  src_vec_t  active_req;
  src_vec_t  pending;
  grant_t    grant;

  // Write channel capture
  logic      aw_held;
  logic      w_held;
  wr_req_t   wr_req;
  wr_state_t wr_state;

  // Pin synchroniser
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= BIDIR_PIN_I;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Pin acts as a request only while it is an input; rising edge requests
  wire bidir_edge = ~bidir_pin_is_output & pin_sync & ~pin_prev;

  always_comb begin
    raw_req = SRC_REQ_I;
    raw_req[`BIT_BIDIR] = SRC_REQ_I[`BIT_BIDIR] | bidir_edge;
  end

  assign BIDIR_PIN_O    = bidir_pin_is_output & interrupt_mask_field[`BIT_BIDIR];
  assign BIDIR_PIN_OE_O = bidir_pin_is_output;

  // mask bit positions, set bit blocks; bit 3 not a mask in output mode
  src_vec_t eff_mask;
  always_comb begin
    eff_mask = interrupt_mask_field;
    if (bidir_pin_is_output) begin
      eff_mask[`BIT_BIDIR] = 1'b0;
    end
  end

  // In output mode the bidir source can only come from its sticky bit's other inputs
  assign active_req = status & enable & ~eff_mask;
  assign pending    = active_req;

  irq_priority_pick u_pick (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .req_i   (pending),
    .grant_o (grant)
  );

  assign IRQ_O    = grant.valid;
  assign VECTOR_O = grant.code;
  assign LEVEL_O  = grant.level;

  // Write decode
  wire       wr_fire   = aw_held & w_held & (wr_state == WR_IDLE);
  wire       wr_lane0  = wr_req.strb[0];
  wire       wr_mask   = wr_fire & wr_lane0 & (wr_req.addr == `ADDR_MASK);
  wire       wr_status = wr_fire & wr_lane0 & (wr_req.addr == `ADDR_STATUS);
  wire       wr_enable = wr_fire & wr_lane0 & (wr_req.addr == `ADDR_ENABLE);
  wire       wr_config = wr_fire & wr_lane0 & (wr_req.addr == `ADDR_CONFIG);
  wire       wr_known  = (wr_req.addr == `ADDR_MASK) | (wr_req.addr == `ADDR_STATUS) |
                         (wr_req.addr == `ADDR_ENABLE) | (wr_req.addr == `ADDR_CONFIG) |
                         (wr_req.addr == `ADDR_VECTOR) | (wr_req.addr == `ADDR_RAW);
  wire [4:0] clr_bits  = wr_status ? wr_req.data[4:0] : 5'h00;

  assign S_AXI_AWREADY = ~aw_held & (wr_state == WR_IDLE);
  assign S_AXI_WREADY  = ~w_held & (wr_state == WR_IDLE);

  // Channel capture and response
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_req       <= '0;
      wr_state     <= WR_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held     <= 1'b1;
        wr_req.addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held      <= 1'b1;
        wr_req.data <= S_AXI_WDATA;
        wr_req.strb <= S_AXI_WSTRB;
      end
      case (wr_state)
        WR_IDLE: begin
          if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            wr_state     <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            wr_state     <= WR_IDLE;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  // Control registers
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      interrupt_mask_field <= `RST_MASK;
      enable               <= `RST_ENABLE;
      bidir_pin_is_output  <= `RST_CONFIG;
    end else begin
      if (wr_mask) begin
        interrupt_mask_field <= wr_req.data[4:0];
      end
      if (wr_enable) begin
        enable <= wr_req.data[4:0];
      end
      if (wr_config) begin
        bidir_pin_is_output <= wr_req.data[0];
      end
    end
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      status <= 5'h00;
    end else begin
      status <= (status & ~clr_bits) | raw_req;
    end
  end

  // Read path
  logic [31:0] next_rdata;
  logic        next_rerr;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (S_AXI_ARADDR)
      `ADDR_MASK:   next_rdata[4:0] = interrupt_mask_field;
      `ADDR_STATUS: next_rdata[4:0] = status;
      `ADDR_ENABLE: next_rdata[4:0] = enable;
      `ADDR_VECTOR: next_rdata[9:0] = {grant.valid, grant.level, grant.code};
      `ADDR_CONFIG: next_rdata[1:0] = {pin_sync, bidir_pin_is_output};
      `ADDR_RAW:    next_rdata[4:0] = raw_req;
      default:      next_rerr = 1'b1;
    endcase
  end

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// ---- testbench/irq_vector_mask_asserts.sv ----
// Port checker for the interrupt vector and mask block
`timescale 1ns/1ps
module irq_vector_mask_asserts (
  // Clock and reset
  input wire logic                 CLK_I,
  input wire logic                 SRST_I,
  // Watched outputs and handshake ready inputs
  input wire logic                 IRQ_O,
  input wire irq_vec_pkg::vector_t VECTOR_O,
  input wire logic [2:0]           LEVEL_O,
  input wire logic                 BIDIR_PIN_O,
  input wire logic                 BIDIR_PIN_OE_O,
  input wire logic                 S_AXI_BVALID,
  input wire logic                 S_AXI_BREADY,
  input wire logic                 S_AXI_RVALID,
  input wire logic                 S_AXI_RREADY
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_timer_vec: assert property (VECTOR_O == 6'h14 |-> LEVEL_O == 3'h5)
    else $error("timer vector level wrong");
  a_bidir_vec: assert property (VECTOR_O == 6'h10 |-> LEVEL_O == 3'h4)
    else $error("bidir vector level wrong");
  a_rx_vec: assert property (LEVEL_O == 3'h1 |-> VECTOR_O == 6'h04 && IRQ_O)
    else $error("receiver vector wrong");
  a_code_level: assert property (IRQ_O |-> VECTOR_O == {1'b0, LEVEL_O, 2'b00} && LEVEL_O <= 3'h5)
    else $error("vector and level disagree");
  a_irq_level: assert property (IRQ_O == (LEVEL_O != 3'h0))
    else $error("irq without level");
  a_pin_idle: assert property (!BIDIR_PIN_OE_O |-> !BIDIR_PIN_O)
    else $error("pin level without enable");
  a_b_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_r_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data repeated");
endmodule
bind irq_vector_mask irq_vector_mask_asserts u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .IRQ_O(IRQ_O),
  .VECTOR_O(VECTOR_O), .LEVEL_O(LEVEL_O), .BIDIR_PIN_O(BIDIR_PIN_O), .BIDIR_PIN_OE_O(BIDIR_PIN_OE_O),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

// ---- testbench/test_interrupt_vector_and_mask.sv ----
// Self-checking bench for the interrupt vector and mask block
`timescale 1ns/1ps
`include "irq_vec_consts.svh"
module test_interrupt_vector_and_mask;
  import irq_vec_pkg::*;
  logic clk, srst, pin_i, awv, wv, bready, arv, rready;
  logic awr, wrdy, bv, arr, rv, irq, pin_o, pin_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r;
  src_vec_t src;
  vector_t vec;
  logic [2:0] lvl;
  integer err_count, num_checks, seed, m, p, e, k, n;
  irq_vector_mask dut (.CLK_I(clk), .SRST_I(srst), .SRC_REQ_I(src), .BIDIR_PIN_I(pin_i),
    .BIDIR_PIN_O(pin_o), .BIDIR_PIN_OE_O(pin_oe), .IRQ_O(irq), .VECTOR_O(vec), .LEVEL_O(lvl),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks = num_checks + 1;
    if (g !== x) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      n = n + 1;
    end while (bv !== 1'b1 && n < 50);
    bready <= 0;
    chk(bresp, `RESP_OKAY);
    if (n >= 50) begin
      err_count = err_count + 1;
      results;
    end
  endtask
  task rd(input logic [11:0] a);
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
      n = n + 1;
    end while (rv !== 1'b1 && n < 50);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 0;
    if (n >= 50) begin
      err_count = err_count + 1;
      results;
    end
  endtask
  // Model: level of the lowest set bit, 0 if none
  function integer lv(input integer v);
    integer i;
    lv = 0;
    for (i = 4; i >= 0; i--) if (v[i]) lv = i + 1;
  endfunction
  initial begin
    srst = 1;
    {pin_i, awv, wv, bready, arv, rready, src} = 0;
    {awaddr, araddr, wdata} = 0;
    err_count = 0;
    num_checks = 0;
    seed = 8;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk(irq, 0);
    rd(`ADDR_MASK);
    chk(rd_d, `RST_MASK);
    wr(`ADDR_ENABLE, 32'h1F);
    // Pin rising edge in input mode raises the bidir request
    @(posedge clk);
    pin_i <= 1;
    repeat (6) @(posedge clk);
    chk(vec, `VEC_BIDIR);
    rd(`ADDR_STATUS);
    chk(rd_d, 32'h0000_0008);
    rd(`ADDR_VECTOR);
    chk(rd_d, 32'h0000_0310);
    pin_i <= 0;
    wr(`ADDR_STATUS, 32'h1F);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    for (k = 0; k < 24; k++) begin
      p = (k < 5) ? (1 << k) : ($random(seed) & 31);
      m = (k < 5) ? 0 : ($random(seed) & 31);
      if (k == 20) wr(`ADDR_CONFIG, 32'h1);
      wr(`ADDR_MASK, m);
      rd(`ADDR_MASK);
      chk(rd_d, m);
      @(posedge clk);
      src <= p;
      @(posedge clk);
      src <= 0;
      repeat (3) @(posedge clk);
      // Output mode frees bit 3 from masking
      e = (p & ~m & 31) | ((k >= 20) ? (p & m & 8) : 0);
      chk(lvl, lv(e));
      chk(vec, lv(e) * 4);
      chk(irq, e != 0);
      chk({pin_oe, pin_o}, (k >= 20) ? {1'b1, m[3]} : 2'b00);
      wr(`ADDR_MASK, 0);
      repeat (3) @(posedge clk);
      chk(vec, lv(p) * 4);
      wr(`ADDR_STATUS, 32'h1F);
      repeat (3) @(posedge clk);
      chk(irq, 0);
    end
    rd(12'h100);
    chk(rd_r, `RESP_SLVERR);
    results;
  end
endmodule
